// [sph_monitor.sv]
// checker for the strobed port handshake block
`timescale 1ns/1ns
module sph_monitor
  import sph_pkg::*;
(
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              resetn,
  // register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic              avs_waitrequest,
  // pins and flags
  input wire logic [BYTE_W-1:0] porta_pins_oe,
  input wire logic [PC_W-1:0]   portc_pins_in,
  input wire logic [PC_W-1:0]   portc_pins_out,
  input wire logic [PC_W-1:0]   portc_pins_oe,
  input wire logic              strobe_irq_n,
  input wire logic              buffer_full
);
  // committed accesses and decoded shadow state
  logic [2:0] mode_r;
  logic       lat_r;
  wire        wc    = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire        rc    = avs_read && !avs_waitrequest;
  wire [7:0]  wd    = avs_writedata[7:0];
  wire        out_m = mode_r[1:0] == 2'h3;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // shadow of mode and bit-2 latch; byte writes only reach the latch in basic mode
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_r <= 3'h0;
      lat_r  <= 1'b0;
    end
    else if (wc)
    begin
      if (avs_address == ADDR_MDR) mode_r <= wd[2:0];
      if (avs_address == ADDR_PCST && wd[2]) lat_r <= 1'b1;
      if (avs_address == ADDR_PCCL && wd[2]) lat_r <= 1'b0;
      if (avs_address == ADDR_PC && !mode_r[0]) lat_r <= wd[2];
    end
  end
  rst_vals_a: assert property ($rose(resetn) |-> strobe_irq_n && !buffer_full)
    else $error("flags wrong after reset");
  wr_full_a: assert property (wc && avs_address == ADDR_PA && out_m |=> buffer_full ##1 strobe_irq_n)
    else $error("port a write did not raise full and release irq");
  mdr_clear_a: assert property (wc && avs_address == ADDR_MDR && mode_r[1] |=> !buffer_full)
    else $error("mode write left full set");
  irq_enable_a: assert property ($fell(strobe_irq_n) |-> lat_r || $past(lat_r))
    else $error("irq asserted with latch clear");
  // strobe rise is seen after the synchroniser, so allow a few edges
  stb_clear_a: assert property (out_m && buffer_full && $rose(portc_pins_in[2]) |-> ##[1:5] !buffer_full)
    else $error("strobe did not clear full");
  hiz_release_a: assert property ((mode_r == 3'h7 && portc_pins_in[2])[*6] |-> porta_pins_oe == 8'h00)
    else $error("port a driven without strobe");
  irq_pin_a: assert property (mode_r[0] && $past(mode_r[0]) && portc_pins_oe[0] |-> portc_pins_out[0] == strobe_irq_n)
    else $error("port c bit 0 differs from irq");
  rd_clear_a: assert property (rc && avs_address == ADDR_PA && mode_r[1:0] == 2'h1 |=> !buffer_full ##1 strobe_irq_n)
    else $error("port a read did not clear handshake");
  // main scenarios reached
  cover property (wc && avs_address == ADDR_PA && out_m);
  cover property (buffer_full && $rose(portc_pins_in[2]));
  cover property (mode_r == 3'h7 && porta_pins_oe == 8'hFF);
endmodule

bind sph_port sph_monitor i_mon (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .porta_pins_oe(porta_pins_oe), .portc_pins_in(portc_pins_in),
  .portc_pins_out(portc_pins_out), .portc_pins_oe(portc_pins_oe), .strobe_irq_n(strobe_irq_n),
  .buffer_full(buffer_full));

// [sph_periph.sv]
// peripheral model on port a: strobe pulses, byte source and sink
`timescale 1ns/1ns
module sph_periph
  import sph_pkg::*;
(
  // clock
  input  wire logic              ref_clk,
  // port a wire level
  input  wire logic [BYTE_W-1:0] pa_wire,
  // strobe, data offered, data taken
  output logic                   strobe_n,
  output logic      [BYTE_W-1:0] pa_out,
  output logic      [BYTE_W-1:0] cap
);
  logic              en_r = 1'b0;
  logic [BYTE_W-1:0] dat_r = 8'h00;
  logic [BYTE_W-1:0] idle_r = 8'h00;
  initial strobe_n = 1'b1;
  initial cap = 8'h00;
  // released lines toggle so a stale byte never passes for fresh data
  always @(posedge ref_clk) idle_r <= ~idle_r;
  assign pa_out = en_r ? dat_r : idle_r;
  // one strobe pulse, low and high for at least three clocks; drv sources a byte
  task automatic pulse(input logic drv, input logic [BYTE_W-1:0] d, input int low);
  begin
    @(posedge ref_clk);
    en_r     <= drv;
    dat_r    <= d;
    strobe_n <= 1'b0;
    repeat (low) @(posedge ref_clk);
    strobe_n <= 1'b1;
    cap      <= pa_wire; // byte taken at the rising strobe
    repeat (4) @(posedge ref_clk);
    en_r <= 1'b0;
  end
  endtask
endmodule

// [sph_port.sv]
// strobed port a handshake block: constants package and top module
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
package sph_pkg;
  // bus geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int PC_W   = 6;
  // register byte addresses, one 32-bit word each
  localparam logic [ADDR_W-1:0] ADDR_PA   = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_PB   = 6'h04;
  localparam logic [ADDR_W-1:0] ADDR_PC   = 6'h08;
  localparam logic [ADDR_W-1:0] ADDR_DDRA = 6'h0C;
  localparam logic [ADDR_W-1:0] ADDR_DDRB = 6'h10;
  localparam logic [ADDR_W-1:0] ADDR_DDRC = 6'h14;
  localparam logic [ADDR_W-1:0] ADDR_MDR  = 6'h18;
  localparam logic [ADDR_W-1:0] ADDR_PCCL = 6'h1C;
  localparam logic [ADDR_W-1:0] ADDR_PCST = 6'h20;
  // reset values
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST   = 6'h00;
  // mode definition register fields
  localparam int MDR_STROBED = 0;
  localparam int MDR_OUTPUT  = 1;
  localparam int MDR_HIGHZ   = 2;
  // handshake positions in port c
  localparam int IRQ_BIT = 0;
  localparam int BF_BIT  = 1;
  localparam int STB_BIT = 2;
  localparam int HS_TOP  = 2;
  localparam logic [1:0]      DDRC_STROBED = 2'h3;
  localparam logic [PC_W-1:0] PC_HS_LOCK   = 6'h03;
  localparam logic [PC_W-1:0] PC_ALL       = 6'h3F;
  // decoded port a modes
  typedef enum logic [1:0] {
    SPH_BASIC,
    SPH_STB_IN,
    SPH_STB_OUT,
    SPH_STB_HIZ
  } sph_mode_t;
endpackage

`timescale 1ns/1ns

// Operation
// - in strobed mode bit-set/clear on irq and full bits are ignored
// - full output runs once port c ddr holds strobed setting, immune to bit ops
// - output mode: setting bit-2 latch asserts irq; port a write releases it
// - output mode: port a write latches data, releases irq, raises full
// - output mode: strobe pulse clears full and reasserts irq
// - high-z output mode drives port a only while strobe is low
// - port c bit 0 is irq, bit 1 is full, bit 2 is strobe
// - irq is active low; input read or output write of port a clears it
// - strobe pin stays input; its latch bit gates the irq condition
// - reset clears bit-2 latch so irq stays disabled
// - in strobed mode bit-2 latch changes only by bit-set/clear
// - strobe active low; data captured on its rising edge
// - full is active high, marks new data in either direction
// - rewriting the mode register clears full; a strobe fall in input mode in the same cycle sets it instead
// - port c stays readable so software can poll handshake
// - after reset basic input mode, irq high, full low
// - input mode: strobe fall loads latch, raises full; rise sets irq
// - input mode: port a read drops full and irq
// - port a data sits at address 00h for read and write
// - reset clears every programmable register to zero
module sph_port
  import sph_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  // port a pins
  input  wire logic [BYTE_W-1:0] porta_pins_in,
  output logic      [BYTE_W-1:0] porta_pins_out,
  output logic      [BYTE_W-1:0] porta_pins_oe,
  // port b pins
  input  wire logic [BYTE_W-1:0] portb_pins_in,
  output logic      [BYTE_W-1:0] portb_pins_out,
  output logic      [BYTE_W-1:0] portb_pins_oe,
  // port c pins, low three carry the handshake
  input  wire logic [PC_W-1:0]   portc_pins_in,
  output logic      [PC_W-1:0]   portc_pins_out,
  output logic      [PC_W-1:0]   portc_pins_oe,
  // handshake copies for the system
  output logic                   strobe_irq_n,
  output logic                   buffer_full
);

  // bus state
  logic                 wait_r;
  logic [DATA_W-1:0]    rdata_r;
  logic [DATA_W-1:0]    rdata_nxt;
  logic [BYTE_W-1:0]    rd_byte;

  // programmable registers
  logic [BYTE_W-1:0]    mdr_r;
  logic [BYTE_W-1:0]    ddra_r;
  logic [BYTE_W-1:0]    ddrb_r;
  logic [PC_W-1:0]      ddrc_r;
  logic [BYTE_W-1:0]    pa_out_r;
  logic [BYTE_W-1:0]    pa_out_nxt;
  logic [BYTE_W-1:0]    pa_in_r;
  logic [BYTE_W-1:0]    pa_in_nxt;
  logic [BYTE_W-1:0]    pb_out_r;
  logic [PC_W-1:0]      pc_out_r;
  logic [PC_W-1:0]      pc_out_nxt;

  // handshake state
  logic                 bf_r;
  logic                 bf_nxt;
  logic                 irq_cond_r;
  logic                 irq_cond_nxt;
  logic                 stb_d_r;

  // pin drive registers
  logic [BYTE_W-1:0]    pa_oe_r;
  logic [BYTE_W-1:0]    pa_oe_nxt;
  logic [PC_W-1:0]      pc_pin_r;
  logic [PC_W-1:0]      pc_pin_nxt;
  logic [PC_W-1:0]      pc_oe_r;
  logic [PC_W-1:0]      pc_oe_nxt;
  logic                 irq_n_r;

  // synchronised pins
  logic [BYTE_W-1:0]    pa_s;
  logic [BYTE_W-1:0]    pb_s;
  logic [PC_W-1:0]      pc_s;

  // pin synchronisers, two flops before any logic
  sph_sync #(.WIDTH(BYTE_W), .RST_VAL(BYTE_RST)) u_sync_pa
  (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .async_in (porta_pins_in),
    .sync_out (pa_s)
  );

  sph_sync #(.WIDTH(BYTE_W), .RST_VAL(BYTE_RST)) u_sync_pb
  (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .async_in (portb_pins_in),
    .sync_out (pb_s)
  );

  // port c idles high so a released strobe does not look like an edge
  sph_sync #(.WIDTH(PC_W), .RST_VAL(PC_ALL)) u_sync_pc
  (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .async_in (portc_pins_in),
    .sync_out (pc_s)
  );

  // bus decode: one wait state, request commits when waitrequest is low
  wire bus_req  = avs_read | avs_write;
  wire bus_go   = bus_req & wait_r;
  wire wr_fire  = avs_write & ~wait_r & avs_byteenable[0];
  wire rd_fire  = avs_read & ~wait_r;
  wire [BYTE_W-1:0] wbyte = avs_writedata[BYTE_W-1:0];
  wire [PC_W-1:0]   wbits = avs_writedata[PC_W-1:0];

  // register hits
  wire wr_pa    = wr_fire & (avs_address == ADDR_PA);
  wire wr_pb    = wr_fire & (avs_address == ADDR_PB);
  wire wr_pc    = wr_fire & (avs_address == ADDR_PC);
  wire wr_ddra  = wr_fire & (avs_address == ADDR_DDRA);
  wire wr_ddrb  = wr_fire & (avs_address == ADDR_DDRB);
  wire wr_ddrc  = wr_fire & (avs_address == ADDR_DDRC);
  wire wr_mdr   = wr_fire & (avs_address == ADDR_MDR);
  wire wr_pccl  = wr_fire & (avs_address == ADDR_PCCL);
  wire wr_pcst  = wr_fire & (avs_address == ADDR_PCST);
  wire rd_pa    = rd_fire & (avs_address == ADDR_PA);

  // mode decode from the mode definition register
  sph_mode_t mode;
  assign mode = !mdr_r[MDR_STROBED] ? SPH_BASIC :
                !mdr_r[MDR_OUTPUT]  ? SPH_STB_IN :
                mdr_r[MDR_HIGHZ]    ? SPH_STB_HIZ : SPH_STB_OUT;

  wire strobed  = (mode != SPH_BASIC);
  wire in_mode  = (mode == SPH_STB_IN);
  wire out_mode = (mode == SPH_STB_OUT) | (mode == SPH_STB_HIZ);
  wire hiz_mode = (mode == SPH_STB_HIZ);
  wire new_out  = wbyte[MDR_STROBED] & wbyte[MDR_OUTPUT];

  // strobe edges taken from the second sync flop only
  wire stb_s    = pc_s[STB_BIT];
  wire stb_fall = stb_d_r & ~stb_s;
  wire stb_rise = ~stb_d_r & stb_s;

  // port c latch: handshake bits are locked while strobed
  wire [PC_W-1:0] bit_mask = strobed ? ~PC_HS_LOCK : PC_ALL;
  wire [PC_W-1:0] byte_val = strobed ? {wbits[PC_W-1:HS_TOP+1], pc_out_r[HS_TOP:0]}
                                     : wbits;
  assign pc_out_nxt = wr_pc   ? byte_val :
                      wr_pcst ? (pc_out_r | (wbits & bit_mask)) :
                      wr_pccl ? (pc_out_r & ~(wbits & bit_mask)) :
                      pc_out_r;

  // port a latches
  assign pa_out_nxt = wr_pa ? wbyte : pa_out_r;
  // input data loads from the pins at the strobe fall and again at the rise, then holds
  assign pa_in_nxt  = (in_mode & (stb_fall | stb_rise)) ? pa_s : pa_in_r;

  // buffer full: a setting event wins over a clear in the same cycle
  wire bf_set = (in_mode & stb_fall)
              | (out_mode & wr_pa);
  wire bf_clr = wr_mdr
              | (in_mode & rd_pa)
              | (out_mode & stb_rise);
  assign bf_nxt = bf_set ? 1'b1 : (bf_clr ? 1'b0 : bf_r);

  // internal interrupt condition, active high before gating
  wire irq_set = strobed & stb_rise;
  wire irq_clr = (in_mode & rd_pa)
               | (out_mode & wr_pa);
  // a mode write restarts the condition: output mode starts asking for data
  assign irq_cond_nxt = wr_mdr  ? new_out :
                        irq_set ? 1'b1 :
                        irq_clr ? 1'b0 : irq_cond_r;

  // latch bit 2 gates the condition onto the active-low pin
  wire irq_n_int = ~(strobed & irq_cond_r & pc_out_r[STB_BIT]);

  // port a drive: high-z mode releases the bus unless strobe is low
  assign pa_oe_nxt = in_mode  ? BYTE_RST :
                     hiz_mode ? (ddra_r & {BYTE_W{~stb_s}}) :
                     ddra_r;

  // port c drive: handshake replaces latch bits 0 and 1, bit 2 input
  assign pc_pin_nxt = strobed ? {pc_out_r[PC_W-1:BF_BIT+1], bf_r, irq_n_int}
                              : pc_out_r;
  assign pc_oe_nxt  = strobed ? {ddrc_r[PC_W-1:STB_BIT+1], 1'b0,
                                 ddrc_r[BF_BIT:0]}
                              : ddrc_r;

  // read selection: basic inputs show the pins, outputs show what is driven; strobed port a shows its latch
  wire [BYTE_W-1:0] pa_basic = (ddra_r & pa_out_r) | (~ddra_r & pa_s);
  wire [BYTE_W-1:0] pa_rd    = !strobed ? pa_basic :
                               in_mode  ? pa_in_r : pa_out_r;
  wire [BYTE_W-1:0] pb_rd    = (ddrb_r & pb_out_r) | (~ddrb_r & pb_s);
  wire [PC_W-1:0]   pc_rd    = (pc_oe_r & pc_pin_r) | (~pc_oe_r & pc_s);

  // read data mux, unmapped and command addresses read zero
  always_comb
  begin
    rd_byte = BYTE_RST;
    unique case (avs_address)
      ADDR_PA:   rd_byte = pa_rd;
      ADDR_PB:   rd_byte = pb_rd;
      ADDR_PC:   rd_byte = {2'b00, pc_rd};
      ADDR_DDRA: rd_byte = ddra_r;
      ADDR_DDRB: rd_byte = ddrb_r;
      ADDR_DDRC: rd_byte = {2'b00, ddrc_r};
      ADDR_MDR:  rd_byte = mdr_r;
      default:   rd_byte = BYTE_RST;
    endcase
    rdata_nxt = {{(DATA_W-BYTE_W){1'b0}}, rd_byte};
  end

  // bus slave: data captured on the first request cycle, held during ack
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wait_r  <= 1'b1;
      rdata_r <= '0;
    end
    else
    begin
      wait_r <= ~bus_go;
      if (bus_go)
        rdata_r <= rdata_nxt;
    end
  end

  // configuration registers, all cleared by reset
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mdr_r    <= BYTE_RST;
      ddra_r   <= BYTE_RST;
      ddrb_r   <= BYTE_RST;
      ddrc_r   <= PC_RST;
      pb_out_r <= BYTE_RST;
    end
    else
    begin
      if (wr_mdr)
        mdr_r <= wbyte;
      if (wr_ddra)
        ddra_r <= wbyte;
      if (wr_ddrb)
        ddrb_r <= wbyte;
      if (wr_ddrc)
        ddrc_r <= wbits;
      if (wr_pb)
        pb_out_r <= wbyte;
    end
  end

  // data latches and handshake state
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pa_out_r   <= BYTE_RST;
      pa_in_r    <= BYTE_RST;
      pc_out_r   <= PC_RST;
      bf_r       <= 1'b0;
      irq_cond_r <= 1'b0;
      stb_d_r    <= 1'b1;
    end
    else
    begin
      pa_out_r   <= pa_out_nxt;
      pa_in_r    <= pa_in_nxt;
      pc_out_r   <= pc_out_nxt;
      bf_r       <= bf_nxt;
      irq_cond_r <= irq_cond_nxt;
      stb_d_r    <= stb_s;
    end
  end

  // pin drivers, registered so every output leaves a flop
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pa_oe_r  <= BYTE_RST;
      pc_pin_r <= PC_RST;
      pc_oe_r  <= PC_RST;
      irq_n_r  <= 1'b1;
    end
    else
    begin
      pa_oe_r  <= pa_oe_nxt;
      pc_pin_r <= pc_pin_nxt;
      pc_oe_r  <= pc_oe_nxt;
      irq_n_r  <= irq_n_int;
    end
  end

  // output wiring, each straight from a register
  assign avs_waitrequest = wait_r;
  assign avs_readdata    = rdata_r;
  assign porta_pins_out  = pa_out_r;
  assign porta_pins_oe   = pa_oe_r;
  assign portb_pins_out  = pb_out_r;
  assign portb_pins_oe   = ddrb_r;
  assign portc_pins_out  = pc_pin_r;
  assign portc_pins_oe   = pc_oe_r;
  assign strobe_irq_n    = irq_n_r;
  assign buffer_full     = bf_r;
endmodule

// [sph_sync.sv]
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns

module sph_sync #(
  parameter int               WIDTH   = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  // pins and synchronised copy
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // first flop feeds only the second, so metastability settles there
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

// [strobed_port_handshake_test.sv]
// self-checking bench for the strobed port handshake block
`timescale 1ns/1ns
module strobed_port_handshake_test
  import sph_pkg::*;
;
  logic              ref_clk = 1'b0;
  logic              resetn = 1'b0;
  logic [ADDR_W-1:0] avs_address = 6'h00;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = 32'h0000_0000;
  logic [3:0]        avs_byteenable = 4'h1;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest, irq_n, full, stb_n;
  logic [BYTE_W-1:0] pa_out, pa_oe, pb_out, pb_oe, pa_per, cap, rdv;
  logic [PC_W-1:0]   pc_out, pc_oe;
  logic [BYTE_W-1:0] pb_in = 8'h00;
  int                failures = 0;
  int                check_count = 0;
  localparam logic [ADDR_W-1:0] ZREGS [6] = '{ADDR_PB, ADDR_DDRA, ADDR_DDRB, ADDR_DDRC, ADDR_MDR, 6'h3C};
  // wire levels: driven bits win, handshake outputs pulled high when idle
  wire [BYTE_W-1:0]  pa_wire = (pa_out & pa_oe) | (pa_per & ~pa_oe);
  wire [PC_W-1:0]    pc_wire = {3'h5, stb_n, pc_out[1:0] | ~pc_oe[1:0]};
  always #25 ref_clk = ~ref_clk;
  sph_port i_dut (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .porta_pins_in(pa_wire),
    .porta_pins_out(pa_out), .porta_pins_oe(pa_oe), .portb_pins_in(pb_in), .portb_pins_out(pb_out),
    .portb_pins_oe(pb_oe), .portc_pins_in(pc_wire), .portc_pins_out(pc_out), .portc_pins_oe(pc_oe),
    .strobe_irq_n(irq_n), .buffer_full(full));
  sph_periph i_per (.ref_clk(ref_clk), .pa_wire(pa_wire), .strobe_n(stb_n), .pa_out(pa_per), .cap(cap));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // one access; request held until waitrequest is sampled low
  task automatic bus(input logic rw, input logic [ADDR_W-1:0] a, input logic [7:0] d);
  begin
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write     <= rw;
    avs_read      <= !rw;
    // no cycle count assumed; the watchdog ends a wait that never finishes
    do
      @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
  begin
    bus(1'b0, a, 8'h00);
    chk(rdv, exp);
  end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic final_report;
  begin
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  // hang guard, far beyond the 165 or so cycles the tests need
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    final_report;
  end
  initial
  begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    chk(irq_n, 1'b1);
    chk(full, 1'b0);
    for (int i = 0; i < 6; i++) rdc(ZREGS[i], 8'h00);
    // active output bring-up, with refused bit operations on the handshake
    wr(ADDR_MDR, 8'h03);
    wr(ADDR_PCST, 8'h03);
    wr(ADDR_DDRA, 8'hFF);
    wr(ADDR_DDRC, 8'h03);
    wr(ADDR_PCST, 8'h03);
    cyc(3);
    chk(full, 1'b0);
    chk(irq_n, 1'b1);
    wr(ADDR_PCST, 8'h04);
    cyc(3);
    chk(irq_n, 1'b0);
    wr(ADDR_PA, 8'h5A);
    cyc(2);
    chk(full, 1'b1);
    chk(irq_n, 1'b1);
    chk(pa_out, 8'h5A);
    wr(ADDR_PCCL, 8'h03);
    wr(ADDR_PC, 8'h00);
    rdc(ADDR_PC, 8'h2F);
    i_per.pulse(1'b0, 8'h00, 4);
    cyc(2);
    chk(cap, 8'h5A);
    chk(full, 1'b0);
    chk(irq_n, 1'b0);
    chk(pc_out[1:0], 2'h0);
    // back-to-back load then mode rewrite
    wr(ADDR_PA, 8'hC3);
    wr(ADDR_MDR, 8'h03);
    cyc(2);
    chk(full, 1'b0);
    wr(ADDR_PCCL, 8'h04);
    wr(ADDR_PA, 8'h81);
    i_per.pulse(1'b0, 8'h00, 3);
    cyc(2);
    chk(irq_n, 1'b1);
    // high-impedance output: pins driven only during the strobe
    wr(ADDR_MDR, 8'h07);
    cyc(6);
    chk(pa_oe, 8'h00);
    fork
      i_per.pulse(1'b0, 8'h00, 8);
      begin
        cyc(7);
        chk(pa_oe, 8'hFF);
      end
    join
    // strobed input
    wr(ADDR_MDR, 8'h01);
    wr(ADDR_DDRA, 8'h00);
    wr(ADDR_DDRC, 8'h07);
    wr(ADDR_PCST, 8'h04);
    i_per.pulse(1'b1, 8'h96, 4);
    cyc(2);
    chk(full, 1'b1);
    chk(irq_n, 1'b0);
    rdc(ADDR_PA, 8'h96);
    cyc(2);
    chk(full, 1'b0);
    chk(irq_n, 1'b1);
    chk(pc_oe, 6'h03);
    // port b stays basic: pins read back as input, then driven
    pb_in <= 8'h69;
    cyc(3);
    rdc(ADDR_PB, 8'h69);
    wr(ADDR_DDRB, 8'hFF);
    wr(ADDR_PB, 8'hA5);
    // a write without its low byte lane must be ignored
    avs_byteenable <= 4'h0;
    wr(ADDR_PB, 8'h11);
    avs_byteenable <= 4'h1;
    cyc(2);
    chk(pb_out, 8'hA5);
    chk(pb_oe, 8'hFF);
    rdc(ADDR_PB, 8'hA5);
    final_report;
  end
endmodule
